// ==== verilog/adcms_pkg.sv ====
package adcms_pkg;

  // Operating modes.
  typedef enum logic [1:0] {
    ADCMS_ONE_SHOT = 2'h0,
    ADCMS_REPEAT   = 2'h1,
    ADCMS_SWEEP    = 2'h2
  } adcms_mode_e;

  // Conversion clock select.
  localparam logic [1:0] ADCMS_CLK_DIV4 = 2'h0;
  localparam logic [1:0] ADCMS_CLK_DIV3 = 2'h1;
  localparam logic [1:0] ADCMS_CLK_DIV2 = 2'h2;
  localparam logic [1:0] ADCMS_CLK_DIV1 = 2'h3;

  // Divider terminal counts, one per clock select.
  localparam logic [1:0] ADCMS_DIVTOP_4 = 2'h3;
  localparam logic [1:0] ADCMS_DIVTOP_3 = 2'h2;
  localparam logic [1:0] ADCMS_DIVTOP_2 = 2'h1;
  localparam logic [1:0] ADCMS_DIVTOP_1 = 2'h0;

  // Idle level of the trigger pin, used to preload the synchroniser.
  localparam logic       ADCMS_PIN_IDLE = 1'b1;

  // Sweep group codes: last channel of the group.
  localparam logic [2:0] ADCMS_SWEEP_LAST0 = 3'h1;
  localparam logic [2:0] ADCMS_SWEEP_LAST1 = 3'h3;
  localparam logic [2:0] ADCMS_SWEEP_LAST2 = 3'h5;
  localparam logic [2:0] ADCMS_SWEEP_LAST3 = 3'h7;

  localparam int         ADCMS_NCH      = 8;
  localparam int         ADCMS_RES_W    = 10;
  // Conversion-clock ticks per conversion.
  localparam logic [4:0] ADCMS_TICKS_8  = 5'h0A;
  localparam logic [4:0] ADCMS_TICKS_10 = 5'h0C;
  // Extra ticks spent sampling when sample-and-hold is on.
  localparam logic [4:0] ADCMS_TICKS_SH = 5'h04;
  localparam logic [9:0] ADCMS_MASK_8   = 10'h0FF;
  localparam logic [9:0] ADCMS_RES_ZERO = 10'h000;

  typedef struct packed {
    adcms_mode_e mode;
    logic        ext_trig_sel;
    logic [1:0]  clk_sel;
    logic        res10;
    logic        sample_hold;
    logic [2:0]  channel;
    logic        sweep_select_high;
    logic        sweep_select_low;
  } adcms_cfg_s;

  typedef enum logic [1:0] {
    ADCMS_IDLE = 2'h0,
    ADCMS_CONV = 2'h1,
    ADCMS_ARM  = 2'h3
  } adcms_state_e;

endpackage : adcms_pkg

// ==== verilog/adcms_sequencer.sv ====
`timescale 1ns/1ps
`default_nettype none

module adcms_sequencer
  import adcms_pkg::*;
(
  // Clock and reset.
  input  wire logic                   mclk,
  input  wire logic                   arst_n,
  // Software control.
  input  wire adcms_cfg_s             cfg,
  input  wire logic                   start_set,
  input  wire logic                   start_clr,
  input  wire logic                   irq_clr,
  // Trigger pin and converter core.
  input  wire logic                   ext_conv_trigger_pin,
  input  wire logic [ADCMS_RES_W-1:0] approx_value,
  // Status.
  output logic                        start_flag,
  output logic                        irq_request,
  output logic                        busy,
  output logic [2:0]                  conv_channel,
  output logic                        sample_active,
  output logic                        conv_tick,
  output logic [ADCMS_NCH-1:0][ADCMS_RES_W-1:0] result
);

  function automatic logic [2:0] sweep_last(input logic hi, input logic lo);
    unique case ({hi, lo})
      2'h0:    sweep_last = ADCMS_SWEEP_LAST0;
      2'h1:    sweep_last = ADCMS_SWEEP_LAST1;
      2'h2:    sweep_last = ADCMS_SWEEP_LAST2;
      default: sweep_last = ADCMS_SWEEP_LAST3;
    endcase
  endfunction : sweep_last

  logic [2:0]   trig_sync_reg, trig_sync_next;
  logic         trig_level_reg, trig_level_next;
  logic         trig_fall;
  logic [1:0]   div_reg, div_next;
  logic [1:0]   div_top;
  adcms_state_e state_reg, state_next;
  logic [4:0]   tick_reg, tick_next;
  logic [4:0]   tick_total;
  logic [2:0]   chan_reg, chan_next;
  logic         start_reg, start_next;
  logic         irq_reg, irq_next;
  logic [ADCMS_NCH-1:0][ADCMS_RES_W-1:0] res_reg, res_next;
  logic         done;
  logic [ADCMS_RES_W-1:0] stored;

  // The trigger is qualified only once the second and third stages agree,
  // so a one-cycle glitch does not count as an edge.
  always_comb begin
    trig_sync_next  = {trig_sync_reg[1:0], ext_conv_trigger_pin};
    trig_level_next = trig_level_reg;
    if (trig_sync_reg[2] == trig_sync_reg[1]) begin
      trig_level_next = trig_sync_reg[2];
    end
  end
  assign trig_fall = trig_level_reg & ~trig_level_next;

  // The divider runs free, so the first tick of a conversion may come up to
  // three clocks after the start; only the number of ticks must be exact.
  always_comb begin
    unique case (cfg.clk_sel)
      ADCMS_CLK_DIV4: div_top = ADCMS_DIVTOP_4;
      ADCMS_CLK_DIV3: div_top = ADCMS_DIVTOP_3;
      ADCMS_CLK_DIV2: div_top = ADCMS_DIVTOP_2;
      default:        div_top = ADCMS_DIVTOP_1;
    endcase
    conv_tick = (div_reg >= div_top);
    div_next  = conv_tick ? 2'h0 : div_reg + 2'h1;
  end

  always_comb begin
    tick_total = cfg.res10 ? ADCMS_TICKS_10 : ADCMS_TICKS_8;
    if (cfg.sample_hold) begin
      tick_total = tick_total + ADCMS_TICKS_SH;
    end
  end

  assign done   = (state_reg == ADCMS_CONV) && conv_tick &&
                  (tick_reg == tick_total - 5'h01);
  assign stored = cfg.res10 ? approx_value : (approx_value & ADCMS_MASK_8);

  always_comb begin
    state_next = state_reg;
    tick_next  = tick_reg;
    chan_next  = chan_reg;
    start_next = start_reg;
    irq_next   = irq_reg & ~irq_clr;
    res_next   = res_reg;
    if (state_reg == ADCMS_CONV && conv_tick) begin
      tick_next = tick_reg + 5'h01;
    end
    unique case (state_reg)
      ADCMS_IDLE: begin
        if (start_set) begin
          start_next = 1'b1;
          tick_next  = 5'h00;
          if (cfg.mode == ADCMS_SWEEP) begin
            chan_next  = 3'h0;
            state_next = ADCMS_CONV;
          end else if (cfg.mode == ADCMS_ONE_SHOT && cfg.ext_trig_sel) begin
            chan_next  = cfg.channel;
            state_next = ADCMS_ARM;
          end else begin
            chan_next  = cfg.channel;
            state_next = ADCMS_CONV;
          end
        end
      end
      ADCMS_ARM: begin
        if (trig_fall) begin
          tick_next  = 5'h00;
          state_next = ADCMS_CONV;
        end
      end
      ADCMS_CONV: begin
        if (cfg.ext_trig_sel && cfg.mode == ADCMS_ONE_SHOT && trig_fall) begin
          tick_next = 5'h00;
        end else if (done) begin
          res_next[chan_reg] = stored;
          tick_next = 5'h00;
          unique case (cfg.mode)
            ADCMS_REPEAT: begin
              // Interrupt request deliberately untouched here.
            end
            ADCMS_SWEEP: begin
              if (chan_reg == sweep_last(cfg.sweep_select_high,
                                         cfg.sweep_select_low)) begin
                irq_next   = 1'b1;
                start_next = 1'b0;
                state_next = ADCMS_IDLE;
              end else begin
                chan_next = chan_reg + 3'h1;
              end
            end
            default: begin
              irq_next = 1'b1;
              if (cfg.ext_trig_sel) begin
                state_next = ADCMS_ARM;
              end else begin
                start_next = 1'b0;
                state_next = ADCMS_IDLE;
              end
            end
          endcase
        end
      end
      default: state_next = ADCMS_IDLE;
    endcase
    // A software clear of the start flag, with start_set low in the same cycle, stops any mode at once.
    if (start_clr && !start_set) begin
      start_next = 1'b0;
      state_next = ADCMS_IDLE;
    end
  end

  // The synchroniser starts at the pin's idle level, so that the release of
  // reset can never look like a falling edge.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      trig_sync_reg  <= {3{ADCMS_PIN_IDLE}};
      trig_level_reg <= ADCMS_PIN_IDLE;
    end else begin
      trig_sync_reg  <= trig_sync_next;
      trig_level_reg <= trig_level_next;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      div_reg <= 2'h0;
    end else begin
      div_reg <= div_next;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg      <= ADCMS_IDLE;
      tick_reg       <= 5'h00;
      chan_reg       <= 3'h0;
      start_reg      <= 1'b0;
      irq_reg        <= 1'b0;
      res_reg        <= '0;
    end else begin
      state_reg      <= state_next;
      tick_reg       <= tick_next;
      chan_reg       <= chan_next;
      start_reg      <= start_next;
      irq_reg        <= irq_next;
      res_reg        <= res_next;
    end
  end

  assign start_flag    = start_reg;
  assign irq_request   = irq_reg;
  assign busy          = (state_reg == ADCMS_CONV);
  assign conv_channel  = chan_reg;
  assign sample_active = busy && cfg.sample_hold && (tick_reg < ADCMS_TICKS_SH);
  assign result        = res_reg;

endmodule : adcms_sequencer

`default_nettype wire

// ==== verification/adcms_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module adcms_properties
  import adcms_pkg::*;
(
  // Clock, reset and controls.
  input wire logic       mclk,
  input wire logic       arst_n,
  input wire adcms_cfg_s cfg,
  input wire logic       start_set,
  input wire logic       start_clr,
  // Status outputs and the interrupt clear.
  input wire logic       start_flag,
  input wire logic       irq_request,
  input wire logic       irq_clr,
  input wire logic       busy,
  input wire logic [2:0] conv_channel,
  input wire logic       sample_active,
  input wire logic       conv_tick
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  a_sw_start: assert property (start_set && !busy && !start_flag &&
    !cfg.ext_trig_sel |=> busy && start_flag) else $error("no start");
  a_sweep_first: assert property (start_set && !busy && !start_flag &&
    cfg.mode == ADCMS_SWEEP |=> conv_channel == 3'h0) else $error("sweep");
  a_done_irq: assert property (
    $fell(start_flag) && !$past(start_clr) && cfg.mode != ADCMS_REPEAT
    |-> irq_request && !busy) else $error("done");
  a_rpt_no_irq: assert property ($rose(irq_request) |->
    cfg.mode != ADCMS_REPEAT) else $error("repeat irq");
  a_clr_stops: assert property (start_clr && !start_set |=>
    !start_flag) else $error("clear");
  a_irq_holds: assert property (irq_request && !irq_clr |=>
    irq_request) else $error("irq lost");
  a_tick_div4: assert property (conv_tick && busy &&
    cfg.clk_sel == ADCMS_CLK_DIV4 |=> !conv_tick [*3] ##1 conv_tick)
    else $error("divider");
  a_one_chan: assert property (busy && cfg.mode != ADCMS_SWEEP |->
    conv_channel == cfg.channel) else $error("channel");
  a_sweep_bound: assert property (
    busy && cfg.mode == ADCMS_SWEEP |->
    conv_channel <= {cfg.sweep_select_high, cfg.sweep_select_low, 1'b1})
    else $error("group");
  a_sample_sh: assert property ($rose(busy) |->
    sample_active == cfg.sample_hold) else $error("sample");
endmodule : adcms_properties
`default_nettype wire

// ==== verification/adcms_far_side.sv ====
`timescale 1ns/1ps
`default_nettype none
module adcms_far_side
  import adcms_pkg::*;
(
  // Bench requests.
  input wire logic                   mclk,
  input wire logic                   trig_req,
  input wire logic [9:0]             base,
  input wire logic [2:0]             conv_channel,
  // Pin and core.
  output logic                       ext_conv_trigger_pin,
  output logic [ADCMS_RES_W-1:0]     approx_value
);
  logic [2:0] low_cnt = 3'h0;
  // The pin idles high and is held low long enough to pass the synchroniser.
  always @(posedge mclk) begin
    if (trig_req) low_cnt <= 3'h6;
    else if (low_cnt != 3'h0) low_cnt <= low_cnt - 3'h1;
  end
  assign ext_conv_trigger_pin = (low_cnt == 3'h0);
  assign approx_value = base ^ {conv_channel, 7'h00};
endmodule : adcms_far_side
`default_nettype wire

// ==== verification/tb_adc_mode_sequencer.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_adc_mode_sequencer;
  import adcms_pkg::*;
  logic mclk = 0, arst_n = 0, start_set = 0, start_clr = 0, irq_clr = 0;
  logic trig_req = 0, start_flag, irq_request, busy, sample_active, conv_tick;
  logic ext_conv_trigger_pin;
  logic [2:0] conv_channel;
  logic [9:0] base = 10'h000, nb, approx_value;
  logic [3:0] nb_seq = 4'h0;
  logic [7:0][9:0] result, prev = '0;
  logic [12:0] n;
  logic [12:0] q[$];
  adcms_cfg_s cfg = '0;
  int seed = 16048, n_errors = 0, total_checks = 0;
  always #50 mclk = ~mclk;
  adcms_sequencer i_dut (.mclk, .arst_n, .cfg, .start_set, .start_clr,
    .irq_clr, .ext_conv_trigger_pin, .approx_value, .start_flag,
    .irq_request, .busy, .conv_channel, .sample_active, .conv_tick, .result);
  adcms_far_side i_far (.mclk, .trig_req, .base, .conv_channel,
    .ext_conv_trigger_pin, .approx_value);
  task close_out();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out
  task chk_res(logic [12:0] e, logic [12:0] g);
    total_checks++;
    if (e !== g) begin
      n_errors++;
      $display("unexpected result: expected %h seen %h", e, g);
    end
  endtask : chk_res
  task chk_bit(string s, logic e, logic g);
    total_checks++;
    if (e !== g) begin
      n_errors++;
      $display("unexpected %s: expected %b seen %b", s, e, g);
    end
  endtask : chk_bit
  task chk_cnt(string s, int e, int g);
    total_checks++;
    if (e != g) begin
      n_errors++;
      $display("unexpected %s: expected %0d seen %0d", s, e, g);
    end
  endtask : chk_cnt
  task cyc(int k); repeat (k) @(posedge mclk); endtask : cyc
  task note(logic [2:0] c);
    logic [9:0] keep;
    keep = cfg.res10 ? 10'h3FF : ADCMS_MASK_8;
    q.push_back({c, (nb ^ {c, 7'h00}) & keep});
  endtask : note
  task waitq(int k);
    while (q.size() != 0 && k > 0) begin k--; cyc(1); end
    if (q.size() != 0) begin n_errors++; close_out(); end
  endtask : waitq
  task pulse_start();
    start_set <= 1;
    cyc(1);
    start_set <= 0;
  endtask : pulse_start
  task pulse_trig();
    trig_req <= 1;
    cyc(1);
    trig_req <= 0;
  endtask : pulse_trig
  // The watcher only sees changes, so the low nibble counts the calls and no
  // new value can equal anything a result register held before.
  task new_base();
    nb_seq = nb_seq + 4'h1;
    nb = {6'($random(seed)), nb_seq};
    base <= nb;
  endtask : new_base
  // Every result register change must match the oldest note. Results are
  // unknown until the first reset edge, so watching waits for release.
  always @(posedge mclk) begin
    if (arst_n) begin
      for (int c = 0; c < 8; c++) begin
        if (result[c] !== prev[c]) begin
          n = q.size() ? q.pop_front() : 13'h1FFF;
          chk_res(n, {c[2:0], result[c]});
        end
      end
    end
    prev <= result;
  end
  task go(adcms_mode_e m, logic [1:0] i);
    cfg <= '{m, 1'b0, i, i[0], i[1], 3'($random(seed)), i[1], i[0]};
    new_base();
    cyc(8);
    for (int c = 0; c < 8; c++) begin
      if (m == ADCMS_SWEEP ? c <= 2 * i + 1 : c == cfg.channel) note(3'(c));
    end
    pulse_start();
    waitq(900);
    cyc(2);
    chk_bit("irq", 1'b1, irq_request);
    chk_bit("start", 1'b0, start_flag);
    irq_clr <= 1;
    cyc(1);
    irq_clr <= 0;
    cyc(8);
  endtask : go
  initial begin
    cyc(12);
    arst_n <= 1;
    cyc(2);
    for (int i = 0; i < 4; i++) begin
      go(ADCMS_ONE_SHOT, 2'(i));
      go(ADCMS_SWEEP, 2'(i));
    end
    cfg <= '{ADCMS_REPEAT, 1'b0, ADCMS_CLK_DIV2, 1'b1, 1'b0, 3'h5, 1'b0, 1'b0};
    new_base();
    cyc(8);
    note(3'h5);
    pulse_start();
    waitq(300);
    chk_bit("irq", 1'b0, irq_request);
    new_base();
    note(3'h5);
    waitq(300);
    start_clr <= 1;
    cyc(1);
    start_clr <= 0;
    cyc(80);
    chk_bit("start", 1'b0, start_flag);
    chk_bit("busy", 1'b0, busy);
    cfg <= '{ADCMS_ONE_SHOT, 1'b1, ADCMS_CLK_DIV4, 1'b1, 1'b0, 3'h2,
             1'b0, 1'b0};
    new_base();
    cyc(8);
    pulse_start();
    cyc(20);
    chk_bit("busy", 1'b0, busy);
    chk_bit("start", 1'b1, start_flag);
    note(3'h2);
    pulse_trig();
    waitq(300);
    cyc(2);
    chk_bit("irq", 1'b1, irq_request);
    new_base();
    note(3'h2);
    pulse_trig();
    cyc(30);
    pulse_trig();
    cyc(35);
    chk_cnt("pending", 1, q.size());
    waitq(300);
    cyc(20);
    close_out();
  end
endmodule : tb_adc_mode_sequencer
bind adcms_sequencer adcms_properties i_props (.mclk, .arst_n, .cfg,
  .start_set, .start_clr, .start_flag, .irq_request, .irq_clr, .busy,
  .conv_channel, .sample_active, .conv_tick);
`default_nettype wire
